// ### hw/ssc_device.sv
// Purpose: Serial register bank and fast-lock control of the synthesizer
// Assumes: core_clk is the phase-detector reference; one PFD cycle per edge
// Notes:   Link wires are asynchronous and pass two flip-flops first
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.

`timescale 1ns/1ps

module ssc_device
	import ssc_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                resetn,
	ssc_link_if.device               link,
	input  wire logic [ERR_W-1:0]    pfdErrNs,
	output logic      [INT_W-1:0]    intDivide,
	output logic      [FRACTION_NUMERATOR_W-1:0]   fractionNumerator,
	output logic      [MOD_W-1:0]    fractionModulus,
	output logic      [PHASE_W-1:0]  phaseSeed,
	output logic      [RDIV_W-1:0]   refDivide,
	output logic                     refHalve,
	output logic                     refDouble,
	output logic                     pumpCurrentBoost,
	output logic      [CELL_W-1:0]   pumpCells,
	output logic      [2:0]          filterSwitchClosed,
	output logic                     fastLock,
	output logic                     lockDetect,
	output logic                     testSelectOutput
);

	// ----------------------------------------------------------------
	// Link synchronisers and edge detect
	// ----------------------------------------------------------------
	logic [2:0] syncA_r;
	logic [2:0] syncB_r;
	logic [2:0] syncC_r;
	wire        clkRise  = syncB_r[0] & ~syncC_r[0];
	wire        loadRise = syncB_r[2] & ~syncC_r[2];

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			syncA_r <= 3'h0;
			syncB_r <= 3'h0;
			syncC_r <= 3'h0;
		end else begin
			syncA_r <= {link.loadStrobe, link.serialData, link.serialClk};
			syncB_r <= syncA_r;
			syncC_r <= syncB_r;
		end
	end

	// ----------------------------------------------------------------
	// Shift register and register bank
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] shift_r;
	logic [WORD_W-1:0] bank_r [NUM_REG];
	logic              chanWrite_r;
	wire  [SEL_W-1:0]  wordSel = shift_r[SEL_W-1:0];

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			shift_r <= '0;
		end else if (clkRise) begin
			shift_r <= {shift_r[WORD_W-2:0], syncB_r[1]};
		end
	end

	generate
		for (genvar g = 0; g < NUM_REG; g++) begin : gBank
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					bank_r[g] <= '0;
				end else if (loadRise && wordSel == SEL_W'(g)) begin
					bank_r[g] <= shift_r;
				end
			end
		end
	endgenerate

	// Channel write seen one cycle late: divider updates next PFD cycle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			chanWrite_r <= 1'b0;
		end else begin
			chanWrite_r <= loadRise && wordSel == SEL_W'(SSC_CHANNEL_DIVIDE_WORD);
		end
	end

	wire [WORD_W-1:0] chanWord  = bank_r[SSC_CHANNEL_DIVIDE_WORD];
	wire [WORD_W-1:0] modWord   = bank_r[SSC_MODULUS_REFERENCE_WORD];
	wire [WORD_W-1:0] phaseWord = bank_r[SSC_PHASE_WORD];
	wire [WORD_W-1:0] muxWord   = bank_r[SSC_MUX_WORD];

	// ----------------------------------------------------------------
	// Applied settings, double buffered by the channel write
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			intDivide         <= '0;
			fractionNumerator <= '0;
			fractionModulus   <= '0;
			phaseSeed         <= '0;
			refDivide         <= '0;
			refHalve          <= 1'b0;
			refDouble         <= 1'b0;
			pumpCurrentBoost  <= 1'b0;
		end else if (chanWrite_r) begin
			intDivide         <= chanWord[INT_LSB +: INT_W];
			fractionNumerator <= chanWord[FRACTION_NUMERATOR_LSB +: FRACTION_NUMERATOR_W];
			fractionModulus   <= modWord[MOD_LSB +: MOD_W];
			phaseSeed         <= phaseWord[PHASE_LSB +: PHASE_W];
			refDivide         <= modWord[RDIV_LSB +: RDIV_W];
			refHalve          <= modWord[HALF_POS];
			refDouble         <= modWord[DBL_POS];
			pumpCurrentBoost  <= modWord[BOOST_POS];
		end
	end

	// ----------------------------------------------------------------
	// Timer clock and timeout values
	// ----------------------------------------------------------------
	logic [1:0]        tdiv_r;
	logic [TOUT_W-1:0] tout_r [4];
	wire               tick = (tdiv_r == 2'(TIMER_DIV - 1));
	wire  [WORD_W-1:0] tmrWord = bank_r[SSC_PUMP_TIMER_WORD];

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tdiv_r <= 2'h0;
		end else begin
			tdiv_r <= tdiv_r + 2'h1;
		end
	end

	// Each timer word write updates the timer named in its select field
	generate
		for (genvar t = 0; t < 4; t++) begin : gTout
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					tout_r[t] <= '0;
				end else if (loadRise && wordSel == 3'(SSC_PUMP_TIMER_WORD)
						&& shift_r[TSEL_LSB +: 2] == 2'(t)) begin
					tout_r[t] <= shift_r[TOUT_LSB +: TOUT_W];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Fast lock sequence
	// ----------------------------------------------------------------
	logic [TOUT_W-1:0] pumpCnt_r;
	logic [TOUT_W-1:0] swCnt_r [3];
	wire               pumpExpired = (pumpCnt_r >= tout_r[SSC_TMR_PUMP]);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pumpCnt_r <= '0;
			pumpCells <= CELLS_MIN;
		end else if (chanWrite_r) begin
			pumpCnt_r <= '0;
			pumpCells <= CELLS_MAX;
		end else if (tick) begin
			if (!pumpExpired) begin
				pumpCnt_r <= pumpCnt_r + TOUT_W'(1);
			end else if (pumpCells != CELLS_MIN) begin
				pumpCells <= pumpCells >> 1;
			end
		end
	end

	// Switches count from the channel write; host pads them by seven
	generate
		for (genvar s = 0; s < 3; s++) begin : gSw
			wire swDone = (swCnt_r[s] >= tout_r[s+1]);
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					swCnt_r[s]            <= '0;
					filterSwitchClosed[s] <= 1'b0;
				end else if (chanWrite_r) begin
					swCnt_r[s]            <= '0;
					filterSwitchClosed[s] <= 1'b1;
				end else if (tick) begin
					if (!swDone) begin
						swCnt_r[s] <= swCnt_r[s] + TOUT_W'(1);
					end else begin
						filterSwitchClosed[s] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fastLock <= 1'b0;
		end else if (chanWrite_r) begin
			fastLock <= 1'b1;
		end else if (pumpCells == CELLS_MIN && filterSwitchClosed == 3'h0) begin
			fastLock <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Lock detect
	// ----------------------------------------------------------------
	logic [5:0]       goodCnt_r;
	wire  [ERR_W-1:0] errLimit = muxWord[LDWIDE_POS] ? ERR_WIDE_NS
	                                                 : ERR_NARROW_NS;
	wire              errGood  = (pfdErrNs < errLimit);
	wire              errLoss  = (pfdErrNs > ERR_LOSS_NS);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			goodCnt_r  <= '0;
			lockDetect <= 1'b0;
		end else if (chanWrite_r || errLoss) begin
			goodCnt_r  <= '0;
			lockDetect <= 1'b0;
		end else if (!errGood) begin
			goodCnt_r <= '0;
		end else if (goodCnt_r == 6'(LOCK_CYCLES - 1)) begin
			lockDetect <= 1'b1;
		end else begin
			goodCnt_r <= goodCnt_r + 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// Test output multiplexer
	// ----------------------------------------------------------------
	logic muxNxt;
	wire  [OSEL_W-1:0] outputSelectField = muxWord[OSEL_LSB +: OSEL_W];

	always_comb begin
		unique case (outputSelectField)
			OSEL_LOCK:    muxNxt = lockDetect;
			OSEL_FAST:    muxNxt = fastLock;
			OSEL_PUMPEXP: muxNxt = pumpExpired;
			OSEL_SW1:     muxNxt = filterSwitchClosed[0];
			OSEL_SW2:     muxNxt = filterSwitchClosed[1];
			OSEL_SW3:     muxNxt = filterSwitchClosed[2];
			OSEL_HIGH:    muxNxt = 1'b1;
			default:      muxNxt = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			testSelectOutput <= 1'b0;
		end else begin
			testSelectOutput <= muxNxt;
		end
	end

endmodule : ssc_device

// ### hw/ssc_host.sv
// Purpose: Wishbone-driven three-wire programmer for the synthesizer
// Assumes: one word in flight; software polls busy or waits for irq
// Notes:   Serial clock made by dividing core_clk

`timescale 1ns/1ps

module ssc_host
	import ssc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq,
	ssc_link_if.host         link
);

	typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_LOAD, S_GAP} ssc_hstate_t;

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	ssc_hstate_t       state_r;
	logic [2:0]        status_r;
	logic [2:0]        mask_r;
	logic [WORD_W-1:0] word_r;
	wire  busy   = (state_r != S_IDLE);
	wire  access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire  wrTx   = access & wb_we_i & (wb_adr_i == HOST_TXDATA);
	wire  wrMask = access & wb_we_i & (wb_adr_i == HOST_MASK)
	               & wb_sel_i[0];
	wire  rdStat = access & ~wb_we_i & (wb_adr_i == HOST_STATUS);
	wire  start  = wrTx & ~busy & (&wb_sel_i[2:0]);
	wire  overrun = wrTx & busy;
	wire  sendDone;
	wire [31:0] rdData = (wb_adr_i == HOST_STATUS) ? {29'h0, status_r[2:1], busy}
	                   : (wb_adr_i == HOST_MASK)   ? {29'h0, mask_r}
	                   : 32'h0;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			mask_r   <= 3'h0;
		end else begin
			wb_ack_o <= access;
			wb_dat_o <= access ? rdData : 32'h0;
			if (wrMask) begin
				mask_r <= wb_dat_i[2:0];
			end
		end
	end

	// Read clears sticky bits, but a same-cycle event still sets
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			status_r <= 3'h0;
		end else begin
			status_r[ST_DONE]    <= sendDone | (status_r[ST_DONE] & ~rdStat);
			status_r[ST_OVERRUN] <= overrun
			                        | (status_r[ST_OVERRUN] & ~rdStat);
			status_r[ST_BUSY]    <= 1'b0;
		end
	end

	assign irq = |(status_r[2:1] & mask_r[2:1]);

	// ----------------------------------------------------------------
	// Serial engine
	// ----------------------------------------------------------------
	logic [2:0] phase_r;
	logic [4:0] bitCnt_r;
	wire        phaseEnd = (phase_r == 3'(2 * SCLK_HALF - 1));
	assign sendDone = (state_r == S_GAP) & phaseEnd;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_r         <= S_IDLE;
			phase_r         <= 3'h0;
			bitCnt_r        <= 5'h0;
			word_r          <= '0;
			link.serialClk  <= 1'b0;
			link.serialData <= 1'b0;
			link.loadStrobe <= 1'b0;
		end else begin
			phase_r <= (state_r == S_IDLE || phaseEnd) ? 3'h0 : phase_r + 3'h1;
			unique case (state_r)
				S_IDLE: begin
					if (start) begin
						state_r         <= S_SHIFT;
						word_r          <= wb_dat_i[WORD_W-1:0];
						link.serialData <= wb_dat_i[WORD_W-1];
						bitCnt_r        <= 5'h0;
					end
				end
				S_SHIFT: begin
					// Data moves only while clock is low
					link.serialClk <= (phase_r >= 3'(SCLK_HALF - 1))
					                  & ~phaseEnd;
					if (phaseEnd) begin
						word_r          <= {word_r[WORD_W-2:0], 1'b0};
						link.serialData <= word_r[WORD_W-2];
						bitCnt_r        <= bitCnt_r + 5'h01;
						if (bitCnt_r == 5'(WORD_W - 1)) begin
							state_r         <= S_LOAD;
							link.loadStrobe <= 1'b1;
						end
					end
				end
				S_LOAD: begin
					if (phaseEnd) begin
						state_r         <= S_GAP;
						link.loadStrobe <= 1'b0;
					end
				end
				S_GAP: begin
					if (phaseEnd) begin
						state_r <= S_IDLE;
					end
				end
			endcase
		end
	end

endmodule : ssc_host

// ### include/ssc_link_if.sv
// Purpose: Three-wire serial programming link
// Assumes: host drives all three wires
// Notes:   No clocking block; both ends sample on core_clk

`timescale 1ns/1ps

interface ssc_link_if;
	logic serialClk;
	logic serialData;
	logic loadStrobe;

	modport host   (output serialClk, output serialData, output loadStrobe);
	modport device (input serialClk, input serialData, input loadStrobe);
endinterface : ssc_link_if

// ### include/ssc_pkg.sv
// Purpose: Shared constants for the synthesizer serial control block
// Assumes: core clock is the phase-detector reference, 50 MHz
// Notes:   Host-side Wishbone offsets live here too

package ssc_pkg;

	// ----------------------------------------------------------------
	// Serial word
	// ----------------------------------------------------------------
	localparam int WORD_W  = 24;
	localparam int SEL_W   = 3;
	localparam int NUM_REG = 8;

	typedef enum logic [2:0] {
		SSC_CHANNEL_DIVIDE_WORD,
		SSC_MODULUS_REFERENCE_WORD,
		SSC_PHASE_WORD,
		SSC_FUNCTION_WORD,
		SSC_PUMP_TIMER_WORD,
		SSC_POWER_WORD,
		SSC_MUX_WORD,
		SSC_TEST_WORD
	} ssc_reg_sel_t;

	// Channel divide word fields
	localparam int INT_LSB  = 15;
	localparam int INT_W    = 8;
	localparam int FRACTION_NUMERATOR_LSB = 3;
	localparam int FRACTION_NUMERATOR_W   = 12;
	// Modulus / reference word fields
	localparam int MOD_LSB   = 3;
	localparam int MOD_W     = 12;
	localparam int RDIV_LSB  = 15;
	localparam int RDIV_W    = 4;
	localparam int DBL_POS   = 19;
	localparam int HALF_POS  = 22;
	localparam int BOOST_POS = 23;
	// Phase word
	localparam int PHASE_LSB = 3;
	localparam int PHASE_W   = 12;
	// Timer word
	localparam int TSEL_LSB = 3;
	localparam int TOUT_LSB = 5;
	localparam int TOUT_W   = 9;
	// Mux word
	localparam int OSEL_LSB   = 3;
	localparam int OSEL_W     = 4;
	localparam int LDWIDE_POS = 12;

	// ----------------------------------------------------------------
	// Fast lock and lock detect
	// ----------------------------------------------------------------
	localparam int TIMER_DIV    = 4;
	localparam int CELL_W       = 7;
	localparam logic [CELL_W-1:0] CELLS_MAX = 7'h40;
	localparam logic [CELL_W-1:0] CELLS_MIN = 7'h01;
	localparam int LOCK_CYCLES  = 40;
	localparam int ERR_W        = 8;
	localparam logic [ERR_W-1:0] ERR_NARROW_NS = 8'h03;
	localparam logic [ERR_W-1:0] ERR_WIDE_NS   = 8'h0A;
	localparam logic [ERR_W-1:0] ERR_LOSS_NS   = 8'h1E;

	typedef enum logic [1:0] {
		SSC_TMR_PUMP,
		SSC_TMR_SW1,
		SSC_TMR_SW2,
		SSC_TMR_SW3
	} ssc_timer_sel_t;

	// Test output selections
	localparam logic [3:0] OSEL_LOW     = 4'h0;
	localparam logic [3:0] OSEL_LOCK    = 4'h1;
	localparam logic [3:0] OSEL_FAST    = 4'h2;
	localparam logic [3:0] OSEL_PUMPEXP = 4'h3;
	localparam logic [3:0] OSEL_SW1     = 4'h4;
	localparam logic [3:0] OSEL_SW2     = 4'h5;
	localparam logic [3:0] OSEL_SW3     = 4'h6;
	localparam logic [3:0] OSEL_HIGH    = 4'hF;

	// ----------------------------------------------------------------
	// Host controller
	// ----------------------------------------------------------------
	localparam int SCLK_HALF = 4;
	localparam logic [3:0] HOST_TXDATA = 4'h0;
	localparam logic [3:0] HOST_STATUS = 4'h4;
	localparam logic [3:0] HOST_MASK   = 4'h8;
	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_OVERRUN = 2;

endpackage : ssc_pkg

// ### tb/ssc_properties.sv
// Purpose: Concurrent checks on the serial link and fast-lock outputs
// Assumes: one clock domain, core_clk, reset resetn active low
// Notes:   Instantiated beside the link interface, no bind

`timescale 1ns/1ps

module ssc_properties
	import ssc_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              resetn,
	input wire logic              serialClk,
	input wire logic              serialData,
	input wire logic              loadStrobe,
	input wire logic [ERR_W-1:0]  pfdErrNs,
	input wire logic [CELL_W-1:0] pumpCells,
	input wire logic [2:0]        filterSwitchClosed,
	input wire logic              fastLock,
	input wire logic              lockDetect
);
	// ----------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------
	// Run of good cycles at the widest threshold; bounds any device count
	logic [7:0] goodRun_r;
	logic [7:0] goodRun_nxt;
	logic [5:0] bitCnt_r;
	logic [5:0] bitCnt_nxt;
	logic       sclkD_r;
	wire        sclkRise = serialClk & ~sclkD_r;
	assign goodRun_nxt = (pfdErrNs >= ERR_WIDE_NS) ? 8'h00 :
		(goodRun_r == 8'hFF) ? goodRun_r : goodRun_r + 8'h01;
	assign bitCnt_nxt = loadStrobe ? 6'h00 :
		(sclkRise ? bitCnt_r + 6'h01 : bitCnt_r);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			goodRun_r <= 8'h00;
			bitCnt_r  <= 6'h00;
			sclkD_r   <= 1'b0;
		end else begin
			goodRun_r <= goodRun_nxt;
			bitCnt_r  <= bitCnt_nxt;
			sclkD_r   <= serialClk;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_load_pulse;
		loadStrobe [*8] ##1 !loadStrobe;
	endsequence
	sequence s_cells_hold;
		$stable(pumpCells) [*3];
	endsequence

	a_load_width: assert property ($rose(loadStrobe) |-> s_load_pulse)
		else $error("load strobe width off");
	a_load_quiet: assert property (loadStrobe |-> !serialClk)
		else $error("serial clock moved during load");
	a_word_bits: assert property ($rose(loadStrobe) |-> bitCnt_r == 6'h18)
		else $error("word not 24 bits");
	a_clk_high: assert property ($rose(serialClk) |-> serialClk [*4] ##1 !serialClk)
		else $error("serial clock high phase off");
	a_data_steady: assert property (serialClk |-> $stable(serialData))
		else $error("data moved while clock high");
	a_full_pump: assert property ($rose(fastLock) |->
		pumpCells == CELLS_MAX && filterSwitchClosed == 3'h7)
		else $error("fast lock entry state wrong");
	a_entry_unlock: assert property ($rose(fastLock) |-> !lockDetect)
		else $error("lock held over new channel");
	a_cells_halve: assert property ((pumpCells < $past(pumpCells)) |->
		pumpCells == ($past(pumpCells) >> 1))
		else $error("pump step not binary");
	a_tick_rate: assert property ((pumpCells < $past(pumpCells)) |=> s_cells_hold)
		else $error("pump steps faster than timer clock");
	a_fast_end: assert property ($fell(fastLock) |->
		pumpCells == CELLS_MIN && filterSwitchClosed == 3'h0)
		else $error("fast lock ended early");
	a_loss_drop: assert property ((pfdErrNs > ERR_LOSS_NS) |=> !lockDetect)
		else $error("lock kept over large error");
	a_lock_run: assert property ($rose(lockDetect) |->
		goodRun_r >= LOCK_CYCLES - 2)
		else $error("lock rose too soon");
endmodule : ssc_properties

// ### tb/synth_serial_ctrl_fastlock_tb.sv
// Purpose: Host and device joined over the link, driven over Wishbone
// Assumes: 50 MHz core clock, one serial word in flight
// Notes:   Read data and applied settings are checked from queues

`timescale 1ns/1ps

module synth_serial_ctrl_fastlock_tb
	import ssc_pkg::*;
;
	logic               core_clk = 1'b0;
	logic               resetn   = 1'b0;
	logic               wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [3:0]         wbAdr = 4'h0, wbSel = 4'h0;
	logic [31:0]        wbDatI = 32'h0, wbDatO;
	logic               wbAck, irq, fastLockD;
	logic [ERR_W-1:0]   pfdErrNs = 8'h14;
	logic [INT_W-1:0]   intDivide;
	logic [FRACTION_NUMERATOR_W-1:0]  fractionNumerator;
	logic [MOD_W-1:0]   fractionModulus;
	logic [PHASE_W-1:0] phaseSeed;
	logic [RDIV_W-1:0]  refDivide;
	logic               refHalve, refDouble, pumpCurrentBoost;
	logic [CELL_W-1:0]  pumpCells;
	logic [2:0]         filterSwitchClosed;
	logic               fastLock, lockDetect, testSelectOutput;
	integer             n_fail = 0, cmp_count = 0, seed = 7806, cycles = 0;
	logic [31:0]        rdQ[$];
	logic [50:0]        chQ[$];
	logic [3:0]         oselTab [0:4] = '{OSEL_LOW, OSEL_LOCK, OSEL_FAST,
		OSEL_SW1, OSEL_HIGH};
	logic               oselExp [0:4] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

	ssc_link_if link ();
	ssc_host ssc_host_inst (.core_clk(core_clk), .resetn(resetn),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
		.wb_ack_o(wbAck), .irq(irq), .link(link));
	ssc_device ssc_device_inst (.core_clk(core_clk), .resetn(resetn),
		.link(link), .pfdErrNs(pfdErrNs), .intDivide(intDivide),
		.fractionNumerator(fractionNumerator),
		.fractionModulus(fractionModulus), .phaseSeed(phaseSeed),
		.refDivide(refDivide), .refHalve(refHalve), .refDouble(refDouble),
		.pumpCurrentBoost(pumpCurrentBoost), .pumpCells(pumpCells),
		.filterSwitchClosed(filterSwitchClosed), .fastLock(fastLock),
		.lockDetect(lockDetect), .testSelectOutput(testSelectOutput));
	ssc_properties ssc_properties_inst (.core_clk(core_clk), .resetn(resetn),
		.serialClk(link.serialClk), .serialData(link.serialData),
		.loadStrobe(link.loadStrobe), .pfdErrNs(pfdErrNs),
		.pumpCells(pumpCells), .filterSwitchClosed(filterSwitchClosed),
		.fastLock(fastLock), .lockDetect(lockDetect));

	always #10 core_clk = ~core_clk;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task final_report;
		if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report

	task chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk

	// Classic cycle; ack is sampled before this edge's updates land
	task wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
		integer k;
		@(posedge core_clk);
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'b11, we, adr, 4'hF, d};
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (wbAck !== 1'b1 && k < 50);
		chk(k < 50, "no acknowledge");
		{wbCyc, wbStb} <= 2'b00;
	endtask : wb

	task rd(input logic [3:0] adr, input logic [31:0] exp);
		rdQ.push_back(exp);
		wb(1'b0, adr, 32'h0);
	endtask : rd

	task wait_irq;
		integer k;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (irq !== 1'b1 && k < 400);
		chk(k < 400, "no interrupt");
	endtask : wait_irq

	task send(input logic [23:0] w);
		wb(1'b1, HOST_TXDATA, {8'h00, w});
		wait_irq();
		rd(HOST_STATUS, 32'h2);
		@(posedge core_clk);
		chk(irq === 1'b0, "interrupt not cleared");
	endtask : send

	// Errors of base plus 0..span-1 for 45 cycles, then the lock state
	task err_run(input logic [7:0] base, input logic [7:0] span,
		input logic expLock);
		integer k;
		for (k = 0; k < 45; k++) begin
			pfdErrNs <= base + 8'({$random(seed)} % span);
			@(posedge core_clk);
			if (k == 35) chk(lockDetect === 1'b0, "lock too early");
		end
		chk(lockDetect === expLock, "lock state after run");
	endtask : err_run

	// ----------------------------------------------------------------
	// Result watcher
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		fastLockD <= fastLock;
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			final_report();
		end
		if (wbAck === 1'b1 && wbWe === 1'b0) begin
			if (rdQ.size() == 0) chk(1'b0, "read without note");
			else chk(wbDatO === rdQ.pop_front(), "read data");
		end
		if (fastLock === 1'b1 && fastLockD !== 1'b1 && chQ.size() != 0)
			chk({phaseSeed, fractionModulus, refDivide, refHalve, refDouble,
				pumpCurrentBoost, intDivide, fractionNumerator}
				=== chQ.pop_front(), "applied settings");
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] rnd;
		logic [11:0] prevMod;
		logic [8:0]  tmo;
		integer      i, j;
		prevMod = 12'h000;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		chk(pumpCells === CELLS_MIN && fastLock === 1'b0, "reset state");
		rd(HOST_STATUS, 32'h0);
		rd(4'hC, 32'h0);
		// Done with mask clear must stay quiet; 208 cycles per word
		wb(1'b1, HOST_TXDATA, 32'h0000_0007);
		repeat (215) @(posedge core_clk);
		chk(irq === 1'b0, "masked interrupt");
		rd(HOST_STATUS, 32'h2);
		wb(1'b1, HOST_MASK, 32'h6);
		rd(HOST_MASK, 32'h6);
		wb(1'b1, HOST_TXDATA, 32'h0000_0023);
		wb(1'b1, HOST_TXDATA, 32'h0000_0015);
		rd(HOST_STATUS, 32'h5);
		wait_irq();
		rd(HOST_STATUS, 32'h2);
		for (i = 3; i < 8; i = i + 2) begin
			rnd = $random(seed);
			send({rnd[20:0], i[2:0]});
		end
		for (i = 0; i < 2; i++) begin
			pfdErrNs <= 8'h14;
			rnd = $random(seed);
			send({rnd[18], rnd[17], 2'b00, rnd[16], rnd[15:0], 3'h1});
			chk(fractionModulus === prevMod, "modulus applied early");
			send({9'h000, rnd[30:19], 3'h2});
			chQ.push_back({rnd[30:19], rnd[11:0], rnd[15:12], rnd[17],
				rnd[16], rnd[18], rnd[7:0], rnd[11:0] ^ 12'hA5A});
			prevMod = rnd[11:0];
			tmo = {6'h00, rnd[2:0]} + 9'h003;
			for (j = 0; j < 4; j++)
				send({10'h000, (j == 0) ? tmo : tmo + 9'h007, j[1:0], 3'h4});
			send({1'b0, rnd[7:0], rnd[11:0] ^ 12'hA5A, 3'h0});
			chk(filterSwitchClosed === 3'h7 && fastLock === 1'b1,
				"fast lock not held");
			j = 0;
			while (fastLock === 1'b1 && j < 1000) begin
				@(posedge core_clk);
				j++;
			end
			chk(pumpCells === CELLS_MIN && filterSwitchClosed === 3'h0,
				"fast lock exit");
			err_run(8'h00, 8'h03, 1'b1);
		end
		for (j = 0; j < 5; j++) begin
			send({16'h0000, 1'b0, oselTab[j], 3'h6});
			chk(testSelectOutput === oselExp[j], "test output");
		end
		@(posedge core_clk);
		pfdErrNs <= 8'h1F;
		@(posedge core_clk);
		pfdErrNs <= 8'h00;
		repeat (3) @(posedge core_clk);
		chk(lockDetect === 1'b0, "lock survived error");
		// Errors of 3 to 9 ns: refused at the narrow threshold, kept wide
		err_run(8'h03, 8'h07, 1'b0);
		pfdErrNs <= 8'h14;
		send({11'h000, 1'b1, 5'h00, OSEL_LOCK, 3'h6});
		err_run(8'h03, 8'h07, 1'b1);
		chk(testSelectOutput === 1'b1, "wide lock on test output");
		final_report();
	end
endmodule : synth_serial_ctrl_fastlock_tb
